// File: hdl/cadc_core.sv
// Setup word holder and result formatter for a 16-channel current converter.
// Assumes pins arrive asynchronously and the analog core gives signed raw samples.
// Operation
// - Two-bit range field picks one common capacitor for all channels and sides.
// - Width field bits 13-12: 00 gives 16 bits, 01 gives 14, 1x gives 12.
// - Narrow words drop low bits of the 16-bit result, no rounding.
// - Offset binary: zero input gives 0492, saturate to FFFF, clamp to 0000.
// - Multiplexed mode sends all 16 channels on lane one; other lanes low.
// - Parallel mode sends four channels at once, one quarter per lane.
// - Every word leaves most significant bit first, ending at the last kept bit.
// - Bit 15 resets to zero; the host always writes it as one.
// - Any reset returns all setup fields to defaults; host rewrites settings.
// - Bit 14 zero selects four-lane output, one selects multiplexed output.
// - Setup bits need preamble 1010 before 16 bits; shifter clears after loading.
// - Ready falls on a clock edge with results; rises on first readout falling edge.
// - Data change on readout falling edges; a setup word loaded outside a measurement is presented on lane one.
// - Unused bits 9, 5 and 3-0 reset to zero and are written as zero.
`timescale 1ns/1ns
`default_nettype none
module cadc_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic setup_serial_in,
  input wire logic integrate_toggle,
  input wire logic readout_clock,
  input wire logic [cadc_pkg::NCH*cadc_pkg::RAW_W-1:0] integrate_toggle_raw,
  output logic [cadc_pkg::NLANE-1:0] serial_out_lane,
  output logic result_ready_n,
  output logic [1:0] full_scale_select,
  output logic fast_integration_n,
  output logic [1:0] test_mode_select,
  output logic ref_buffer_off,
  output logic integration_short
);
  import cadc_pkg::*;

  typedef enum logic [2:0] {
    CADC_IDLE = 3'b001,
    CADC_MEAS = 3'b010,
    CADC_READ = 3'b100
  } cadc_phase_e;

  typedef struct packed {
    logic din_s1;
    logic din_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_d;
    logic rck_s1;
    logic rck_s2;
    logic rck_d;
    logic [FRAME_W-1:0] shifter;
    logic [SETUP_W-1:0] setup;
    cadc_phase_e phase;
    logic [CNT_W-1:0] meas_cnt;
    logic [CNT_W-1:0] int_cnt;
    logic int_short;
    logic [NCH-1:0][15:0] store;
    logic cfg_rb;
    logic [3:0] bit_idx;
    logic [3:0] word_idx;
    logic ready_n;
    logic [NLANE-1:0] lanes;
  } cadc_state_s;

  cadc_state_s st_reg;
  cadc_state_s st_next;
  logic [NCH-1:0][15:0] fmt_code;
  logic [1:0] width_sel;
  logic tdm;
  logic rck_fall;
  logic tog_edge;
  logic load_cfg;
  logic meas_done;

  assign width_sel = st_reg.setup[BIT_WIDTH_HI:BIT_WIDTH_LO];
  assign tdm = st_reg.setup[BIT_TDM_MODE];

  // Per-channel offset, clamp and truncation of raw samples
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_fmt
      logic signed [RAW_W:0] sum;
      logic [15:0] clamped;
      assign sum = $signed({integrate_toggle_raw[g*RAW_W+RAW_W-1], integrate_toggle_raw[g*RAW_W +: RAW_W]})
        + $signed(ZERO_CODE);
      assign clamped = sum < 0 ? 16'h0000 :
        (sum > $signed(FULL_CODE) ? 16'hFFFF : sum[15:0]);
      assign fmt_code[g] = width_sel == WIDTH_16 ? clamped :
        (width_sel == WIDTH_14 ? (clamped & KEEP_14) : (clamped & KEEP_12));
    end
  endgenerate

  // Next state of the whole block
  always_comb begin
    logic [3:0] last_bit;
    logic [3:0] last_word;
    logic one_lane;
    logic [3:0] ch;
    st_next = st_reg;
    last_bit = LAST_BIT_12;
    last_word = LAST_WORD_PAR;
    one_lane = 1'b0;
    ch = 4'h0;
    // Two-flop synchronisers and edge detection on the third stage
    st_next.din_s1 = setup_serial_in;
    st_next.din_s2 = st_reg.din_s1;
    st_next.tog_s1 = integrate_toggle;
    st_next.tog_s2 = st_reg.tog_s1;
    st_next.tog_d = st_reg.tog_s2;
    st_next.rck_s1 = readout_clock;
    st_next.rck_s2 = st_reg.rck_s1;
    st_next.rck_d = st_reg.rck_s2;
    tog_edge = st_reg.tog_d ^ st_reg.tog_s2;
    rck_fall = st_reg.rck_d & ~st_reg.rck_s2;
    // Setup serial shifter; a matching preamble loads the word and clears it
    load_cfg = st_reg.shifter[FRAME_W-1:FRAME_W-4] == PREAMBLE;
    if (load_cfg) begin
      st_next.setup = st_reg.shifter[SETUP_W-1:0];
      st_next.shifter = '0;
    end else begin
      st_next.shifter = {st_reg.shifter[FRAME_W-2:0], st_reg.din_s2};
    end
    // Integration length check between toggle edges
    if (tog_edge) begin
      st_next.int_short = st_reg.int_cnt <
        (st_reg.setup[BIT_FAST_N] ? MIN_INT_NORMAL : MIN_INT_FAST);
      st_next.int_cnt = '0;
    end else if (st_reg.int_cnt != CNT_MAX) begin
      st_next.int_cnt = st_reg.int_cnt + 10'd1;
    end
    meas_done = 1'b0;
    // Measurement timing and readout sequencing
    unique case (st_reg.phase)
      CADC_IDLE, CADC_READ: begin
        if (st_reg.phase == CADC_READ && rck_fall) begin
          st_next.ready_n = 1'b1;
          last_bit = st_reg.cfg_rb ? LAST_BIT_16 : (width_sel == WIDTH_16 ? LAST_BIT_16 :
            (width_sel == WIDTH_14 ? LAST_BIT_14 : LAST_BIT_12));
          last_word = st_reg.cfg_rb ? 4'h0 : (tdm ? LAST_WORD_TDM : LAST_WORD_PAR);
          if (st_reg.bit_idx == last_bit) begin
            st_next.bit_idx = 4'h0;
            if (st_reg.word_idx == last_word) begin
              st_next.phase = CADC_IDLE;
            end else begin
              st_next.word_idx = st_reg.word_idx + 4'h1;
            end
          end else begin
            st_next.bit_idx = st_reg.bit_idx + 4'h1;
          end
        end
        if (load_cfg) begin
          st_next.store[0] = st_reg.shifter[SETUP_W-1:0];
          st_next.cfg_rb = 1'b1;
          st_next.bit_idx = 4'h0;
          st_next.word_idx = 4'h0;
          st_next.ready_n = 1'b0;
          st_next.phase = CADC_READ;
        end
      end
      CADC_MEAS: begin
        if (st_reg.meas_cnt == '0) begin
          meas_done = 1'b1;
          st_next.store = fmt_code;
          st_next.cfg_rb = 1'b0;
          st_next.bit_idx = 4'h0;
          st_next.word_idx = 4'h0;
          st_next.ready_n = 1'b0;
          st_next.phase = CADC_READ;
        end else begin
          st_next.meas_cnt = st_reg.meas_cnt - 10'd1;
        end
      end
      default: begin
        st_next.phase = CADC_IDLE;
      end
    endcase
    // A toggle edge starts a new measurement and ends any pending readout
    if (tog_edge) begin
      st_next.meas_cnt = (st_reg.setup[BIT_FAST_N] ? MEAS_NORMAL : MEAS_FAST) - 10'd1;
      st_next.phase = CADC_MEAS;
    end
    // Output lanes follow the readout pointers, most significant bit first
    one_lane = st_next.cfg_rb | st_next.setup[BIT_TDM_MODE];
    for (int k = 0; k < NLANE; k++) begin
      ch = one_lane ? st_next.word_idx : {st_next.word_idx[1:0], 2'(k)};
      if (st_next.phase != CADC_READ || (one_lane && k != 0)) begin
        st_next.lanes[k] = 1'b0;
      end else begin
        st_next.lanes[k] = st_next.store[ch][4'hF - st_next.bit_idx];
      end
    end
  end

  // State register; reset restores the setup defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.setup <= SETUP_RESET;
      st_reg.phase <= CADC_IDLE;
      st_reg.int_cnt <= CNT_MAX;
      st_reg.ready_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign serial_out_lane = st_reg.lanes;
  assign result_ready_n = st_reg.ready_n;
  assign full_scale_select = st_reg.setup[BIT_RANGE_HI:BIT_RANGE_LO];
  assign fast_integration_n = st_reg.setup[BIT_FAST_N];
  assign test_mode_select = st_reg.setup[BIT_TEST_HI:BIT_TEST_LO];
  assign ref_buffer_off = st_reg.setup[BIT_REF_OFF];
  assign integration_short = st_reg.int_short;

  // Checks
  chk_tdm_upper_low: assert property (@(posedge clk) disable iff (rst)
    st_reg.setup[BIT_TDM_MODE] |-> serial_out_lane[3:1] == 3'h0)
    else $error("upper lanes active in multiplexed mode");
  chk_ready_falls_result: assert property (@(posedge clk) disable iff (rst)
    (meas_done && !tog_edge) |=> !result_ready_n)
    else $error("ready did not fall with results");
  chk_ready_rises_fall: assert property (@(posedge clk) disable iff (rst)
    (st_reg.phase == CADC_READ && rck_fall && !load_cfg && !meas_done) |=> result_ready_n)
    else $error("ready did not rise on readout falling edge");
  chk_preamble_load_clear: assert property (@(posedge clk) disable iff (rst)
    load_cfg |=> st_reg.setup == $past(st_reg.shifter[15:0]) && st_reg.shifter == '0)
    else $error("setup word not loaded or shifter not cleared");
  chk_width_trunc_low: assert property (@(posedge clk) disable iff (rst)
    (meas_done && width_sel[1]) |=> st_reg.store[2][3:0] == 4'h0)
    else $error("12-bit word keeps low bits");
  chk_zero_code_offset: assert property (@(posedge clk) disable iff (rst)
    (meas_done && width_sel == WIDTH_16 && integrate_toggle_raw[2*RAW_W-1:RAW_W] == '0 && !load_cfg)
    |=> st_reg.store[1] == 16'h0492)
    else $error("zero input does not give offset code");
  chk_saturate_full: assert property (@(posedge clk) disable iff (rst)
    (meas_done && !load_cfg && !integrate_toggle_raw[NCH*RAW_W-1]
      && integrate_toggle_raw[(NCH-1)*RAW_W+RAW_W-2:(NCH-1)*RAW_W+16] != '0)
    |=> st_reg.store[NCH-1] == (width_sel == WIDTH_16 ? 16'hFFFF :
      (width_sel == WIDTH_14 ? KEEP_14 : KEEP_12)))
    else $error("large input does not saturate");
  chk_setup_presented: assert property (@(posedge clk) disable iff (rst)
    (load_cfg && !tog_edge && !(st_reg.phase == CADC_MEAS && st_reg.meas_cnt == '0))
    |=> !result_ready_n && serial_out_lane[0] == $past(st_reg.shifter[15]))
    else $error("new setup word not presented on lane one");
  // Reset values and setup fields
  chk_reset_defaults: assert property (@(posedge clk)
    $fell(rst) |-> st_reg.setup == SETUP_RESET && !st_reg.setup[BIT_FIXED_ONE]
      && (st_reg.setup & ~SETUP_USED_MASK) == 16'h0000 && result_ready_n
      && serial_out_lane == '0 && !integration_short)
    else $error("setup or outputs not at reset values");
  chk_range_common: assert property (@(posedge clk) disable iff (rst)
    load_cfg |=> full_scale_select == $past(st_reg.shifter[BIT_RANGE_HI:BIT_RANGE_LO]))
    else $error("range field not taken from setup word");
  chk_mode_from_setup: assert property (@(posedge clk) disable iff (rst)
    load_cfg |=> tdm == $past(st_reg.shifter[BIT_TDM_MODE]))
    else $error("output mode not taken from setup word");
  // Output width and truncation
  chk_width_14_low: assert property (@(posedge clk) disable iff (rst)
    (meas_done && width_sel == WIDTH_14) |=> st_reg.store[2][1:0] == 2'h0)
    else $error("14-bit word keeps low bits");
  // Lane use in each output mode
  chk_par_lane_map: assert property (@(posedge clk) disable iff (rst)
    (meas_done && !tog_edge && !load_cfg && !tdm) |=> serial_out_lane ==
      {st_reg.store[3][15], st_reg.store[2][15], st_reg.store[1][15], st_reg.store[0][15]})
    else $error("parallel lanes do not carry four channels at once");
  chk_tdm_first_word: assert property (@(posedge clk) disable iff (rst)
    (meas_done && !tog_edge && !load_cfg && tdm)
    |=> serial_out_lane == {3'h0, st_reg.store[0][15]} && st_reg.word_idx == 4'h0)
    else $error("multiplexed readout does not open with channel zero");
  chk_tdm_word_order: assert property (@(posedge clk) disable iff (rst)
    (st_reg.phase == CADC_READ && rck_fall && tdm && !st_reg.cfg_rb && !tog_edge
      && !load_cfg && width_sel == WIDTH_16 && st_reg.bit_idx == LAST_BIT_16
      && st_reg.word_idx != LAST_WORD_TDM)
    |=> st_reg.word_idx == $past(st_reg.word_idx) + 4'h1 && st_reg.bit_idx == 4'h0)
    else $error("multiplexed words not back to back in channel order");
  chk_idle_lanes_low: assert property (@(posedge clk) disable iff (rst)
    st_reg.phase != CADC_READ |-> serial_out_lane == '0)
    else $error("lanes not low outside readout");
  chk_lanes_hold: assert property (@(posedge clk) disable iff (rst)
    (st_reg.phase == CADC_READ && !rck_fall && !load_cfg && !tog_edge)
    |=> $stable(serial_out_lane))
    else $error("lanes changed without a readout falling edge");
  // Integration length flag
  chk_short_set: assert property (@(posedge clk) disable iff (rst)
    (tog_edge && st_reg.int_cnt < MIN_INT_FAST) |=> integration_short)
    else $error("short integration not flagged");
  chk_short_clear: assert property (@(posedge clk) disable iff (rst)
    (tog_edge && st_reg.int_cnt == CNT_MAX) |=> !integration_short)
    else $error("long integration flagged as short");
  cov_setup_load: cover property (@(posedge clk) disable iff (rst) load_cfg);
  cov_tdm_readout: cover property (@(posedge clk) disable iff (rst)
    tdm && st_reg.phase == CADC_READ && st_reg.word_idx == LAST_WORD_TDM);
  cov_par_readout: cover property (@(posedge clk) disable iff (rst)
    !tdm && st_reg.phase == CADC_READ && !st_reg.cfg_rb && st_reg.word_idx == LAST_WORD_PAR);
  cov_short_flag: cover property (@(posedge clk) disable iff (rst) $rose(integration_short));
  cov_width_12: cover property (@(posedge clk) disable iff (rst) meas_done && width_sel[1]);
endmodule
`default_nettype wire

// File: hdl/cadc_pkg.sv
// Constants for the current converter setup word and result readout.
// Assumes a single system clock domain; the core synchronises its own pin inputs.
package cadc_pkg;
  // Setup word layout and reset value
  localparam int SETUP_W = 16;
  localparam int BIT_FIXED_ONE = 15;
  localparam int BIT_TDM_MODE = 14;
  localparam int BIT_WIDTH_HI = 13;
  localparam int BIT_WIDTH_LO = 12;
  localparam int BIT_RANGE_HI = 11;
  localparam int BIT_RANGE_LO = 10;
  localparam int BIT_FAST_N = 8;
  localparam int BIT_TEST_HI = 7;
  localparam int BIT_TEST_LO = 6;
  localparam int BIT_REF_OFF = 4;
  localparam logic [15:0] SETUP_RESET = 16'h0110;
  localparam logic [15:0] SETUP_USED_MASK = 16'hFDD0;
  // Setup serial framing
  localparam int FRAME_W = 20;
  localparam logic [3:0] PREAMBLE = 4'hA;
  // Output width select codes
  localparam logic [1:0] WIDTH_16 = 2'h0;
  localparam logic [1:0] WIDTH_14 = 2'h1;
  localparam logic [3:0] LAST_BIT_16 = 4'hF;
  localparam logic [3:0] LAST_BIT_14 = 4'hD;
  localparam logic [3:0] LAST_BIT_12 = 4'hB;
  localparam logic [15:0] KEEP_14 = 16'hFFFC;
  localparam logic [15:0] KEEP_12 = 16'hFFF0;
  // Result code
  localparam int RAW_W = 18;
  localparam logic [18:0] ZERO_CODE = 19'h00492;
  localparam logic [18:0] FULL_CODE = 19'h0FFFF;
  // Channels and lanes
  localparam int NCH = 16;
  localparam int NLANE = 4;
  localparam logic [3:0] LAST_WORD_TDM = 4'hF;
  localparam logic [3:0] LAST_WORD_PAR = 4'h3;
  // Timing in system clock periods
  localparam int CNT_W = 10;
  localparam logic [9:0] MEAS_FAST = 10'd274;
  localparam logic [9:0] MEAS_NORMAL = 10'd544;
  localparam logic [9:0] MIN_INT_FAST = 10'd400;
  localparam logic [9:0] MIN_INT_NORMAL = 10'd800;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
endpackage

// File: sim/cadc_host_model.sv
// Host model: drives the integrate toggle and the readout clock and shifts result words in.
// Assumes the bench calls its tasks; every change lands on a falling clk edge.
`timescale 1ns/1ns
`default_nettype none
module cadc_host_model (
  input wire logic clk,
  input wire logic [3:0] lanes,
  output logic integrate_toggle,
  output logic readout_clock
);
  // Both lines idle low; the readout clock never runs free
  initial begin
    integrate_toggle = 1'b0;
    readout_clock = 1'b0;
  end
  // Flip the toggle; the caller spaces the edges, at times closer than the minimum integration time
  task automatic toggle();
    @(negedge clk) integrate_toggle = ~integrate_toggle;
  endtask
  // Shift one w-bit word per lane, MSB first; 180 ns period, low between frames
  task automatic read_word(input int w, output logic [3:0][15:0] v);
    v = '0;
    repeat (w) begin
      @(negedge clk) readout_clock = 1'b1;
      repeat (4) @(negedge clk);
      for (int k = 0; k < 4; k++) v[k] = {v[k][14:0], lanes[k]};
      readout_clock = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

// File: sim/current_adc_config_and_readout_bench.sv
// Bench for the converter setup word and result readout.
// Assumes a 50 MHz clock and the host model on the toggle and readout pins.
`timescale 1ns/1ns
`default_nettype none
module current_adc_config_and_readout_bench;
  import cadc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sin = 1'b0;
  logic tog, rck, ready_n, fin, rbo, short;
  logic [1:0] fss, tms;
  logic [3:0] lanes;
  logic [NCH*RAW_W-1:0] integrate_toggle_raw;
  logic [3:0][15:0] v;
  int n_fail = 0;
  int checked = 0;
  // System clock, 20 ns period
  always #10 clk = ~clk;
  cadc_core cadc_core_i (.clk(clk), .rst(rst), .setup_serial_in(sin), .integrate_toggle(tog),
    .readout_clock(rck), .integrate_toggle_raw(integrate_toggle_raw), .serial_out_lane(lanes), .result_ready_n(ready_n),
    .full_scale_select(fss), .fast_integration_n(fin), .test_mode_select(tms),
    .ref_buffer_off(rbo), .integration_short(short));
  cadc_host_model cadc_host_model_i (.clk(clk), .lanes(lanes), .integrate_toggle(tog),
    .readout_clock(rck));
  // Raw sample per channel: clamps low, one zero input, saturates high
  function automatic int rawv(input int n);
    return (n == 1) ? 0 : n * 4660 - 1536;
  endfunction
  // Expected 16-bit offset binary code
  function automatic logic [15:0] code(input int n);
    int e;
    e = rawv(n) + 1170;
    if (e < 0) return 16'h0000;
    if (e > 65535) return 16'hFFFF;
    return e[15:0];
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Reset field values, idle lanes and ready high
  task automatic chk_defaults();
    chk("fields", 16'h0009, {10'h0, fss, fin, tms, rbo});
    chk("idle", 16'h0001, {11'h0, lanes, ready_n});
  endtask
  // One frame: preamble then 16 bits MSB first, one bit per clock, pin back to 0
  task automatic write_setup(input logic [3:0] pre, input logic [15:0] w);
    logic [19:0] f;
    f = {pre, w};
    for (int i = 19; i >= 0; i--) @(negedge clk) sin = f[i];
    @(negedge clk) sin = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic wait_ready();
    int t;
    t = 0;
    while (ready_n !== 1'b0 && t < 1000) begin
      @(negedge clk);
      t++;
    end
    chk("ready_n", 16'h0, {15'h0, ready_n});
  endtask
  // Watchdog: the whole run needs well under 1 ms
  initial begin
    #1000000;
    n_fail++;
    $display("[ERR] watchdog expected end seen timeout");
    stop_test();
  end
  // Main sequence
  initial begin
    logic [15:0] s;
    int nb;
    for (int n = 0; n < NCH; n++) integrate_toggle_raw[n*RAW_W +: RAW_W] = RAW_W'(rawv(n));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk_defaults();
    write_setup(4'hB, 16'hFFFF);
    chk_defaults();
    write_setup(4'hA, 16'hC540);
    chk("fields", 16'h001A, {10'h0, fss, fin, tms, rbo});
    wait_ready();
    cadc_host_model_i.read_word(16, v);
    chk("readback", 16'hC540, v[0]);
    cadc_host_model_i.toggle();
    wait_ready();
    for (int n = 0; n < NCH; n++) begin
      cadc_host_model_i.read_word(16, v);
      chk("tdm word", code(n), v[0]);
      chk("tdm lanes", 16'h0, v[1] | v[2] | v[3]);
    end
    cadc_host_model_i.toggle();
    repeat (5) @(negedge clk);
    chk("short", 16'h0, {15'h0, short});
    repeat (100) @(negedge clk);
    cadc_host_model_i.toggle();
    repeat (5) @(negedge clk);
    chk("short", 16'h1, {15'h0, short});
    wait_ready();
    cadc_host_model_i.read_word(1, v);
    // Parallel mode at 14 and both 12-bit codes; fast integration only with 12 bits
    for (int w = 1; w < 4; w++) begin
      s = {2'b10, 2'(w), 3'b000, 1'(w != 3), 8'h10};
      write_setup(4'hA, s);
      wait_ready();
      cadc_host_model_i.read_word(16, v);
      chk("readback", s, v[0]);
      repeat (200) @(negedge clk);
      cadc_host_model_i.toggle();
      wait_ready();
      nb = (w == 1) ? 14 : 12;
      for (int i = 0; i < 4; i++) begin
        cadc_host_model_i.read_word(nb, v);
        for (int k = 0; k < 4; k++) chk("lane word", code(4 * i + k) >> (16 - nb), v[k]);
      end
    end
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk_defaults();
    stop_test();
  end
endmodule
`default_nettype wire
